// File: logic/vcocal_pkg.sv
`default_nettype none
// =====================================================================
// Shared constants and types
package vcocal_pkg;
   // Register byte indices; bus byte address is four times the index
   localparam logic [7:0] IDX_TRIM = 8'h59;
   localparam logic [7:0] IDX_CALRST = 8'h5c;
   localparam logic [7:0] IDX_CTRL = 8'h5d;
   localparam logic [7:0] IDX_STATUS = 8'h5e;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
   localparam logic [7:0] IDX_OSC_MEAS = 8'h72;
   // Reset values
   localparam logic [6:0] TRIM_RESET = 7'h00;
   localparam logic [2:0] SETTLE_RESET = 3'h4;
   localparam logic [7:0] CTRL_RESET = 8'h40;
   // Field positions
   localparam int SETTLE_LSB = 4;
   localparam int SETTLE_MSB = 6;
   localparam int TRIM_MSB = 6;
   // Settle time: base 1 us, doubled per select step
   localparam int CLOCK_MHZ = 200;
   localparam int SETTLE_BASE_NS = 1000;
   localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS * CLOCK_MHZ) / 1000;
   localparam int CNT_W = 16;
   // Interrupt bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_START = 1;
   localparam logic [1:0] IRQ_ALL = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [3:0] {
      VCOCAL_IDLE = 4'h1,
      VCOCAL_STEP = 4'h2,
      VCOCAL_SETTLE = 4'h4,
      VCOCAL_DONE = 4'h8
   } vcocal_state_e;

   typedef struct packed {
      logic [7:0] index;
      logic write;
   } vcocal_addr_s;

   typedef struct packed {
      logic pending;
      vcocal_addr_s addr;
      logic [6:0] trim;
      logic calReset;
      logic calEnable;
      logic [2:0] settleSel;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic [31:0] rdata;
   } vcocal_regs_s;
endpackage
`default_nettype wire

// File: logic/vcocal_search.sv
`default_nettype none
// =====================================================================
// Binary search of the oscillator trim code
module vcocal_search (
   input wire logic clock,
   input wire logic resetN,
   input wire logic start,
   input wire logic [2:0] settleSel,
   input wire logic oscFast,
   output logic busy,
   output logic doneStrobe,
   output logic [6:0] trimOut
);
   typedef struct packed {
      vcocal_pkg::vcocal_state_e state;
      logic [6:0] trim;
      logic [6:0] bitMask;
      logic [vcocal_pkg::CNT_W-1:0] count;
   } vcocal_srch_s;

   vcocal_srch_s state_reg;
   vcocal_srch_s state_next;

   // Settle cycles grow with the select field
   function automatic logic [vcocal_pkg::CNT_W-1:0] settleCycles(input logic [2:0] sel);
      logic [31:0] cyc;
      cyc = 32'(vcocal_pkg::SETTLE_BASE_CYC) << sel;
      settleCycles = cyc[vcocal_pkg::CNT_W-1:0];
   endfunction

   // =====================================================================
   // Search sequencing
   always_comb begin
      state_next = state_reg;
      doneStrobe = 1'b0;
      unique case (state_reg.state)
         vcocal_pkg::VCOCAL_IDLE: begin
            if (start) begin
               state_next.trim = 7'h40;
               state_next.bitMask = 7'h40;
               state_next.count = settleCycles(settleSel);
               state_next.state = vcocal_pkg::VCOCAL_SETTLE;
            end
         end
         vcocal_pkg::VCOCAL_SETTLE: begin
            if (state_reg.count <= 1) begin
               state_next.state = vcocal_pkg::VCOCAL_STEP;
            end else begin
               state_next.count = state_reg.count - 1'b1;
            end
         end
         // keep or drop the trial bit
         vcocal_pkg::VCOCAL_STEP: begin
            if (oscFast) begin
               state_next.trim = state_reg.trim & ~state_reg.bitMask;
            end
            state_next.bitMask = state_reg.bitMask >> 1;
            if (state_reg.bitMask == 7'h01) begin
               state_next.state = vcocal_pkg::VCOCAL_DONE;
            end else begin
               state_next.trim = (oscFast ? (state_reg.trim & ~state_reg.bitMask) : state_reg.trim)
                  | (state_reg.bitMask >> 1);
               state_next.count = settleCycles(settleSel);
               state_next.state = vcocal_pkg::VCOCAL_SETTLE;
            end
         end
         vcocal_pkg::VCOCAL_DONE: begin
            doneStrobe = 1'b1;
            state_next.state = vcocal_pkg::VCOCAL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge resetN) begin
      if (!resetN) begin
         state_reg <= '{vcocal_pkg::VCOCAL_IDLE, 7'h00, 7'h00, '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign busy = (state_reg.state != vcocal_pkg::VCOCAL_IDLE);
   assign trimOut = state_reg.trim;
endmodule
`default_nettype wire

// File: logic/vcocal_top.sv
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
// Operation
// - Seven-bit trim code, engine and software writable
// - Enabled calibration starts when reset cleared
// - Engine searches trim to centre oscillator
// - Settle select lengthens wait per step
// - Completion flag set when done or skipped
module vcocal_top (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic oscFast,
   output logic [6:0] oscillatorTrimCode,
   output logic synthPllCalReset,
   output logic calBusy,
   output logic irq
);
   typedef struct packed {
      vcocal_pkg::vcocal_regs_s regs;
      logic calComplete;
   } vcocal_top_s;

   vcocal_top_s top_reg;
   vcocal_top_s top_next;
   logic [1:0] resetSync_reg;
   logic resetN;
   logic searchBusy;
   logic searchDone;
   logic [6:0] searchTrim;
   logic startPulse;

   // =====================================================================
   // Reset release through two flops, kept apart so the state struct has one writer
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         resetSync_reg <= 2'b00;
      end else begin
         resetSync_reg <= {resetSync_reg[0], 1'b1};
      end
   end
   assign resetN = resetSync_reg[1];

   // Register read mux
   function automatic logic [31:0] readReg(input vcocal_pkg::vcocal_regs_s r, input logic done);
      readReg = 32'h0000_0000;
      unique case (r.addr.index)
         vcocal_pkg::IDX_TRIM: readReg = {25'h0, r.trim};
         vcocal_pkg::IDX_CALRST: readReg = {31'h0, r.calReset};
         vcocal_pkg::IDX_CTRL: readReg = {25'h0, r.settleSel, 3'h0, r.calEnable};
         vcocal_pkg::IDX_STATUS: readReg = {31'h0, done};
         vcocal_pkg::IDX_IRQ_STAT: readReg = {30'h0, r.irqStat};
         vcocal_pkg::IDX_IRQ_MASK: readReg = {30'h0, r.irqMask};
         default: readReg = 32'h0000_0000;
      endcase
   endfunction

   // =====================================================================
   // Bus slave, calibration control and interrupts
   always_comb begin
      logic [1:0] events;
      logic wr;
      events = 2'b00;
      top_next = top_reg;
      wr = top_reg.regs.pending && top_reg.regs.addr.write;
      startPulse = 1'b0;
      // Data phase write
      if (wr) begin
         unique case (top_reg.regs.addr.index)
            vcocal_pkg::IDX_TRIM: top_next.regs.trim = hwdata[vcocal_pkg::TRIM_MSB:0];
            vcocal_pkg::IDX_CALRST: begin
               top_next.regs.calReset = hwdata[0];
               if (top_reg.regs.calReset && !hwdata[0]) begin
                  startPulse = top_reg.regs.calEnable;
                  top_next.calComplete = !top_reg.regs.calEnable;
               end
            end
            vcocal_pkg::IDX_CTRL: begin
               top_next.regs.calEnable = hwdata[0];
               top_next.regs.settleSel = hwdata[vcocal_pkg::SETTLE_MSB:vcocal_pkg::SETTLE_LSB];
            end
            vcocal_pkg::IDX_IRQ_STAT: top_next.regs.irqStat = top_reg.regs.irqStat & ~hwdata[1:0];
            vcocal_pkg::IDX_IRQ_MASK: top_next.regs.irqMask = hwdata[1:0];
            default: top_next.regs.irqMask = top_next.regs.irqMask;
         endcase
      end
      if (top_next.regs.calReset && top_next.regs.calEnable) begin
         top_next.calComplete = 1'b0;
      end
      if (startPulse) begin
         top_next.calComplete = 1'b0;
      end
      if (searchBusy) begin
         top_next.regs.trim = searchTrim;
      end
      if (searchDone) begin
         top_next.regs.trim = searchTrim;
         top_next.calComplete = 1'b1;
      end
      // Set wins over clear
      events[vcocal_pkg::IRQ_DONE] = searchDone || (startPulse == 1'b0 && wr
         && top_reg.regs.addr.index == vcocal_pkg::IDX_CALRST && top_reg.regs.calReset
         && !hwdata[0] && !top_reg.regs.calEnable);
      events[vcocal_pkg::IRQ_START] = startPulse;
      top_next.regs.irqStat = top_next.regs.irqStat | events;
      // Address phase capture
      top_next.regs.pending = hsel && hready && (htrans == vcocal_pkg::HTRANS_NONSEQ);
      if (top_next.regs.pending) begin
         top_next.regs.addr.index = haddr[9:2];
         top_next.regs.addr.write = hwrite;
      end
      // Read data registered into data phase
      top_next.regs.rdata = readReg(top_next.regs, top_next.calComplete);
   end

   // Control state register
   always_ff @(posedge clock or negedge resetN) begin
      if (!resetN) begin
         top_reg.regs <= '{1'b0, '{8'h00, 1'b0}, vcocal_pkg::TRIM_RESET, 1'b0, 1'b0,
            vcocal_pkg::SETTLE_RESET, 2'b00, 2'b00, 32'h0000_0000};
         top_reg.calComplete <= 1'b0;
      end else begin
         top_reg.regs <= top_next.regs;
         top_reg.calComplete <= top_next.calComplete;
      end
   end

   // =====================================================================
   // Trim search engine
   vcocal_search search (
      .clock(clock),
      .resetN(resetN),
      .start(startPulse),
      .settleSel(top_reg.regs.settleSel),
      .oscFast(oscFast),
      .busy(searchBusy),
      .doneStrobe(searchDone),
      .trimOut(searchTrim)
   );

   // Zero wait states; always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = top_reg.regs.rdata;
   assign oscillatorTrimCode = top_reg.regs.trim;
   assign synthPllCalReset = top_reg.regs.calReset;
   assign calBusy = searchBusy;
   assign irq = |(top_reg.regs.irqStat & top_reg.regs.irqMask);
endmodule
`default_nettype wire

// File: tb/vcocal_props.sv
`default_nettype none
// ==========
// Port checks of the calibration block
module vcocal_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [6:0] oscillatorTrimCode,
   input wire logic synthPllCalReset,
   input wire logic calBusy
);
   logic take;
   logic wrTrimHit;
   logic wrRstHit;
   // Address phase decode
   assign take = hsel && hready && htrans == vcocal_pkg::HTRANS_NONSEQ;
   assign wrTrimHit = take && hwrite && haddr[9:2] == vcocal_pkg::IDX_TRIM;
   assign wrRstHit = take && hwrite && haddr[9:2] == vcocal_pkg::IDX_CALRST;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence wrCalRst;
      wrRstHit ##1 1'b1;
   endsequence
   sequence wrTrim;
      wrTrimHit ##1 !calBusy;
   endsequence
   sequence stepTaken;
      calBusy && $changed(oscillatorTrimCode);
   endsequence
   calrst_follow_a: assert property (wrCalRst |=> synthPllCalReset == $past(hwdata[0]))
      else $error("reset bit not written");
   calrst_hold_a: assert property ($changed(synthPllCalReset) |-> $past(wrRstHit, 2))
      else $error("reset bit moved alone");
   start_release_a: assert property ($rose(calBusy) |->
      !synthPllCalReset && ($past(synthPllCalReset) || $past(synthPllCalReset, 2)))
      else $error("search start without release");
   trim_write_a: assert property (wrTrim |=> oscillatorTrimCode == $past(hwdata[6:0]))
      else $error("trim write lost");
   trim_hold_a: assert property ($changed(oscillatorTrimCode) |->
      calBusy || $past(calBusy) || $past(wrTrimHit, 2))
      else $error("trim moved unasked");
   step_settle_a: assert property (stepTaken |=> $stable(oscillatorTrimCode) [*8])
      else $error("trim step without settle");
   trim_read_a: assert property (take && !hwrite && haddr[9:2] == vcocal_pkg::IDX_TRIM && !calBusy
      |=> hrdata == {25'h0, oscillatorTrimCode})
      else $error("trim readback wrong");
   status_bits_a: assert property (take && !hwrite && haddr[9:2] == vcocal_pkg::IDX_STATUS
      |=> hrdata[31:1] == 31'h0)
      else $error("status reserved bits set");
endmodule
`default_nettype wire

// File: tb/tb_vcocal_top.sv
`default_nettype none
// ==========
// Bench for the calibration block
module tb_vcocal_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] TARGET = 7'h2b;
   logic clock, resetN, hsel, hwrite, hreadyout, hresp, calRst, calBusy, irq;
   logic oscFast = 1'b0;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [6:0] trim;
   int mismatches, totalChecks, n, cycles;
   vcocal_top dut (.clock(clock), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .oscFast(oscFast), .oscillatorTrimCode(trim),
      .synthPllCalReset(calRst), .calBusy(calBusy), .irq(irq));
   // Clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // Oscillator comparator: fast above the target code
   always @(posedge clock) oscFast <= trim > TARGET;
   // Hang guard, far above one search at settle zero
   always @(posedge clock) begin
      cycles++;
      if (cycles == 10000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
      totalChecks++;
      if (a !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, a);
      end
   endtask
   // One single word transfer: address phase, then data phase
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clock);
      htrans <= vcocal_pkg::HTRANS_NONSEQ;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      xfer(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string nm);
      xfer(1'b0, idx, 32'h0);
      chk(nm, e, v);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic ckIrq(input logic e);
      repeat (2) @(negedge clock);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   // Main sequence
   initial begin
      {resetN, hsel, hwrite, haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      repeat (20) @(posedge clock);
      resetN <= 1'b1;
      hsel <= 1'b1;
      repeat (3) @(posedge clock);
      rd(vcocal_pkg::IDX_TRIM, 0, "trim");
      rd(vcocal_pkg::IDX_CTRL, 32'h40, "ctrl");
      rd(vcocal_pkg::IDX_STATUS, 0, "status");
      rd(8'h60, 0, "unmapped");
      wr(vcocal_pkg::IDX_TRIM, 32'h55);
      rd(vcocal_pkg::IDX_TRIM, 32'h55, "trim rw");
      $display("test registers done");
      wr(vcocal_pkg::IDX_CALRST, 1);
      wr(vcocal_pkg::IDX_CTRL, 0);
      wr(vcocal_pkg::IDX_CALRST, 0);
      rd(vcocal_pkg::IDX_STATUS, 1, "skip done");
      $display("test skip done");
      wr(vcocal_pkg::IDX_IRQ_MASK, 1);
      wr(vcocal_pkg::IDX_CALRST, 1);
      wr(vcocal_pkg::IDX_CTRL, 1);
      rd(vcocal_pkg::IDX_STATUS, 0, "pending");
      rd(vcocal_pkg::IDX_CTRL, 1, "ctrl rw");
      wr(vcocal_pkg::IDX_CALRST, 0);
      repeat (2) @(negedge clock);
      chk("busy", 1, calBusy);
      while (calBusy === 1'b1) begin
         @(negedge clock);
         n++;
      end
      chk("settle", 1, n >= 1390 && n < 1500);
      rd(vcocal_pkg::IDX_STATUS, 1, "cal done");
      rd(vcocal_pkg::IDX_TRIM, TARGET, "trim result");
      chk("trim pin", TARGET, trim);
      ckIrq(1'b1);
      wr(vcocal_pkg::IDX_IRQ_MASK, 0);
      ckIrq(1'b0);
      wr(vcocal_pkg::IDX_IRQ_MASK, 1);
      ckIrq(1'b1);
      wr(vcocal_pkg::IDX_IRQ_STAT, 3);
      ckIrq(1'b0);
      $display("test search done");
      summarize();
   end
endmodule
bind vcocal_top vcocal_checker chk_i (.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .oscillatorTrimCode(oscillatorTrimCode), .synthPllCalReset(synthPllCalReset), .calBusy(calBusy));
`default_nettype wire
